// ### shared/bcs_pkg.sv
// constants, register map and state encoding for the battery charge sequencer
`default_nettype none
package bcs_pkg;
  localparam int CLK_KHZ = 40000;
  // qualification windows, figures in their own units
  localparam int DEAD_QUAL_US = 256;
  localparam int DEAD_QUAL_CYC = (DEAD_QUAL_US * CLK_KHZ + 999) / 1000;
  localparam int QUAL_MS = 16;
  localparam int QUAL_CYC = QUAL_MS * CLK_KHZ;
  localparam int TERM_QUAL_MS = 750;
  localparam int TERM_QUAL_CYC = TERM_QUAL_MS * CLK_KHZ;
  localparam int BLINK_HZ = 1;
  localparam int BLINK_HALF_CYC = (CLK_KHZ * 1000) / (2 * BLINK_HZ);
  localparam int SEC_CYC = CLK_KHZ * 1000;
  localparam int STRT_UNIT_MS = 100;
  localparam int STRT_UNIT_CYC = STRT_UNIT_MS * CLK_KHZ;
  // safety timer limits in seconds
  localparam int LOWBAT_LIMIT_H = 2;
  localparam int LOWBAT_LIMIT_S = LOWBAT_LIMIT_H * 3600;
  localparam int FAST_STEP_MIN = 30;
  localparam int FAST_STEP_S = FAST_STEP_MIN * 60;
  localparam int TMR_W = 16;
  // register offsets
  localparam logic [7:0] ADDR_SHORT_CFG = 8'h0b;
  localparam logic [7:0] ADDR_STRT_CFG = 8'h0d;
  localparam logic [7:0] ADDR_AUX_REGULATOR_LO = 8'h11;
  localparam logic [7:0] ADDR_AUX_REGULATOR_HI = 8'h12;
  localparam logic [7:0] ADDR_IFAST = 8'h18;
  localparam logic [7:0] ADDR_PRE_END = 8'h19;
  localparam logic [7:0] ADDR_FTMR = 8'h1b;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  // field positions
  localparam int SHORT_LVL_LSB = 0;
  localparam int SHORT_CUR_LSB = 4;
  localparam int STRT_LSB = 0;
  localparam int AUX_REGULATOR_HI_LSB = 0;
  localparam int IFAST_LSB = 0;
  localparam int END_LSB = 0;
  localparam int PRE_LSB = 4;
  localparam int FTMR_LSB = 0;
  // reset values
  localparam logic [7:0] RST_SHORT_CFG = 8'h11;
  localparam logic [7:0] RST_STRT_CFG = 8'h01;
  localparam logic [7:0] RST_AUX_REGULATOR_LO = 8'h00;
  localparam logic [7:0] RST_AUX_REGULATOR_HI = 8'h04;
  localparam logic [7:0] RST_IFAST = 8'h64;
  localparam logic [7:0] RST_PRE_END = 8'h52;
  localparam logic [7:0] RST_FTMR = 8'h07;
  // current source selection
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_DEAD = 3'h1;
  localparam logic [2:0] MODE_SHORT = 3'h2;
  localparam logic [2:0] MODE_PRE = 3'h3;
  localparam logic [2:0] MODE_FAST = 3'h4;
  typedef enum logic [10:0] {
    ST_RESET = 11'h001,
    ST_DEAD = 11'h002,
    ST_SHORT = 11'h004,
    ST_SHORT_HOLD = 11'h008,
    ST_PRE = 11'h010,
    ST_PRE_HOLD = 11'h020,
    ST_FAST = 11'h040,
    ST_FAST_HOLD = 11'h080,
    ST_FULL = 11'h100,
    ST_END = 11'h200,
    ST_FAULT = 11'h400
  } bcs_state_e;
endpackage
`default_nettype wire

// ### core/bcs_qual.sv
// continuous-hold qualifier: done once cond has held for CYC cycles
`default_nettype none
module bcs_qual #(
  parameter int CYC = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cond,
  output logic done
);
  logic [31:0] cnt;

  if (CYC < 1) begin : g_bad_cyc
    $error("bcs_qual: CYC must be at least 1");
  end

  // any lapse restarts the window
  always_ff @(posedge clk) begin
    if (!rst_n || !cond) begin // RL25
      cnt <= 32'h0;
    end else if (!done) begin
      cnt <= cnt + 32'h1;
    end
  end

  assign done = cond && (cnt >= 32'(CYC - 1));
endmodule // bcs_qual
`default_nettype wire

// ### core/bcs_safety_timer.sv
// pausable seconds timer with clear and limit compare
`default_nettype none
module bcs_safety_timer #(
  parameter int SEC_CYC = bcs_pkg::SEC_CYC,
  parameter int LIM_W = bcs_pkg::TMR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic run,
  input wire logic [LIM_W-1:0] limit_s,
  output logic expired
);
  logic [31:0] pre;
  logic [LIM_W-1:0] secs;
  logic sec_tick;

  if (SEC_CYC < 1 || LIM_W < 1) begin : g_bad_par
    $error("bcs_safety_timer: bad parameter");
  end

  assign sec_tick = run && (pre == 32'(SEC_CYC - 1));

  // prescaler pauses with the count, so a hold loses no partial second
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      pre <= 32'h0;
    end else if (sec_tick) begin
      pre <= 32'h0;
    end else if (run) begin
      pre <= pre + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      secs <= '0;
    end else if (sec_tick && secs != '1) begin
      secs <= secs + 1'b1;
    end
  end

  assign expired = secs >= limit_s;
endmodule // bcs_safety_timer
`default_nettype wire

// ### core/bcs_sequencer.sv
// battery charge sequencer: state machine, safety timers, status pin, registers
// What this block does
// RL1: start in reset, wait selected startup delay
// RL2: reset state clears both safety timers
// RL3: status pin low in early charge states
// RL4: startup delay expiry always enters dead battery
// RL5: dead battery sources 10mA, exits after 256us
// RL6: low-battery timer runs in dead battery
// RL7: short battery charges at programmable current
// RL8: short to precondition after 16ms above level
// RL9: low-battery timer cumulative, two hour limit
// RL10: timeouts, overvoltage, undervoltage, regulator fault go fault; checked only in short, precondition and fast
// RL11: short battery has its own temperature hold
// RL12: precondition has its own temperature hold
// RL13: disabling temperature sense releases any hold
// RL14: low-battery timer pauses in temperature holds; in the fast hold it is held cleared
// RL15: status pin blinks 1Hz in temperature holds
// RL16: precharge current 5 to 20 percent
// RL17: precondition to fast after 16ms above low
// RL18: fast charge constant current then constant voltage
// RL19: low current 750ms leaves fast charge
// RL20: regulation voltage eleven bits over two registers
// RL21: fast current percent and end current fields
// RL22: fast entry clears low-battery, starts fast timer
// RL23: end enable picks end state, else full
// RL24: fast returns to precondition below low 16ms
// RL25: qualification windows need continuous condition
`default_nettype none
module bcs_sequencer #(
  parameter int DEAD_QUAL_CYC = bcs_pkg::DEAD_QUAL_CYC,
  parameter int QUAL_CYC = bcs_pkg::QUAL_CYC,
  parameter int TERM_QUAL_CYC = bcs_pkg::TERM_QUAL_CYC,
  parameter int BLINK_HALF_CYC = bcs_pkg::BLINK_HALF_CYC,
  parameter int SEC_CYC = bcs_pkg::SEC_CYC,
  parameter int STRT_UNIT_CYC = bcs_pkg::STRT_UNIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  // mode and analog comparator inputs
  input wire logic charge_enable,
  input wire logic vin_ok,
  input wire logic vbat_above_3v,
  input wire logic vbat_above_short,
  input wire logic vbat_above_low,
  input wire logic vbat_at_reg,
  input wire logic fast_charge_current_below_end,
  input wire logic temp_out_of_range,
  input wire logic temp_sense_enable,
  input wire logic end_enable,
  input wire logic vbat_ov,
  input wire logic vin_ov,
  input wire logic vin_uv,
  input wire logic aux_regulator_fault,
  input wire logic regulator_fault_mask,
  // register port from the serial slave
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // charge status open-drain pin
  input wire logic charge_status_n_i,
  output logic charge_status_n_o,
  output logic charge_status_n_oe_n,
  // regulation controls
  output logic switching_en,
  output logic [2:0] charge_mode,
  output logic cv_mode,
  output logic [10:0] charge_state,
  output logic [3:0] short_battery_level,
  output logic [2:0] short_battery_current,
  output logic [3:0] precharge_current,
  output logic [3:0] end_of_charge_current,
  output logic [6:0] fast_current_percent,
  output logic [10:0] regulation_voltage_code
);
  bcs_pkg::bcs_state_e state, next_state;
  logic [7:0] short_battery_config, startup_delay_config, charge_voltage_low;
  logic [7:0] charge_voltage_high, fast_current_scale, precharge_and_end_current;
  logic [7:0] safety_timer_config;
  logic [1:0] startup_delay_select;
  logic [4:0] fast_timer_limit;
  logic [31:0] strt_cnt, strt_limit, blink_cnt;
  logic strt_done, blink_level, temp_hold_req, temp_clear, fault_any, in_hold, drive_low;
  logic dead_ok, short_ok, pre_ok, fast_low, end_ok;
  logic lowbat_clear, lowbat_run, lowbat_expired, fast_clear, fast_run, fast_expired;
  logic [bcs_pkg::TMR_W-1:0] fast_limit_s;
  logic [3:0] state_index;

  if (DEAD_QUAL_CYC < 1 || QUAL_CYC < 1 || TERM_QUAL_CYC < 1 || BLINK_HALF_CYC < 1 ||
      SEC_CYC < 1 || STRT_UNIT_CYC < 1) begin : g_bad_par
    $error("bcs_sequencer: timing parameters must be at least 1");
  end

  // register fields
  assign startup_delay_select = startup_delay_config[bcs_pkg::STRT_LSB +: 2];
  assign fast_timer_limit = safety_timer_config[bcs_pkg::FTMR_LSB +: 5];

  always_comb begin
    short_battery_level = short_battery_config[bcs_pkg::SHORT_LVL_LSB +: 4];
    short_battery_current = short_battery_config[bcs_pkg::SHORT_CUR_LSB +: 3]; // RL7
    precharge_current = precharge_and_end_current[bcs_pkg::PRE_LSB +: 4]; // RL16
    end_of_charge_current = precharge_and_end_current[bcs_pkg::END_LSB +: 4]; // RL21
    fast_current_percent = fast_current_scale[bcs_pkg::IFAST_LSB +: 7]; // RL21
    regulation_voltage_code = {charge_voltage_high[bcs_pkg::AUX_REGULATOR_HI_LSB +: 3],
                               charge_voltage_low}; // RL20
  end

  // register writes; unmapped offsets are ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      short_battery_config <= bcs_pkg::RST_SHORT_CFG;
      startup_delay_config <= bcs_pkg::RST_STRT_CFG;
      charge_voltage_low <= bcs_pkg::RST_AUX_REGULATOR_LO;
      charge_voltage_high <= bcs_pkg::RST_AUX_REGULATOR_HI;
      fast_current_scale <= bcs_pkg::RST_IFAST;
      precharge_and_end_current <= bcs_pkg::RST_PRE_END;
      safety_timer_config <= bcs_pkg::RST_FTMR;
    end else if (reg_wr_en) begin
      case (reg_addr)
        bcs_pkg::ADDR_SHORT_CFG: short_battery_config <= reg_wr_data;
        bcs_pkg::ADDR_STRT_CFG: startup_delay_config <= reg_wr_data;
        bcs_pkg::ADDR_AUX_REGULATOR_LO: charge_voltage_low <= reg_wr_data;
        bcs_pkg::ADDR_AUX_REGULATOR_HI: charge_voltage_high <= reg_wr_data;
        bcs_pkg::ADDR_IFAST: fast_current_scale <= reg_wr_data;
        bcs_pkg::ADDR_PRE_END: precharge_and_end_current <= reg_wr_data;
        bcs_pkg::ADDR_FTMR: safety_timer_config <= reg_wr_data;
        default: ;
      endcase
    end
  end

  // an illegal one-hot code reads back as f
  always_comb begin
    state_index = 4'hf;
    for (int k = 0; k < $bits(state); k++) begin
      if (state == 11'(1 << k)) state_index = 4'(k);
    end
  end

  // read data is registered one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        bcs_pkg::ADDR_SHORT_CFG: reg_rd_data <= short_battery_config;
        bcs_pkg::ADDR_STRT_CFG: reg_rd_data <= startup_delay_config;
        bcs_pkg::ADDR_AUX_REGULATOR_LO: reg_rd_data <= charge_voltage_low;
        bcs_pkg::ADDR_AUX_REGULATOR_HI: reg_rd_data <= charge_voltage_high;
        bcs_pkg::ADDR_IFAST: reg_rd_data <= fast_current_scale;
        bcs_pkg::ADDR_PRE_END: reg_rd_data <= precharge_and_end_current;
        bcs_pkg::ADDR_FTMR: reg_rd_data <= safety_timer_config;
        bcs_pkg::ADDR_STATUS: reg_rd_data <= {fast_expired, lowbat_expired, 1'b0,
                                              cv_mode, state_index};
        default: reg_rd_data <= 8'h00;
      endcase
    end
  end

  // startup delay: (select+1) units, counted only while input is valid
  assign strt_limit = 32'((int'(startup_delay_select) + 1) * STRT_UNIT_CYC);
  assign strt_done = vin_ok && (strt_cnt >= strt_limit - 32'h1);

  always_ff @(posedge clk) begin
    if (!rst_n || state != bcs_pkg::ST_RESET || !vin_ok) begin // RL1
      strt_cnt <= 32'h0;
    end else if (!strt_done) begin
      strt_cnt <= strt_cnt + 32'h1;
    end
  end

  // qualifiers; each restarts on state change because cond includes the state
  bcs_qual #(.CYC(DEAD_QUAL_CYC)) u_dead_qual (
    .clk(clk),
    .rst_n(rst_n),
    .cond(state == bcs_pkg::ST_DEAD && vbat_above_3v), // RL5
    .done(dead_ok)
  );
  bcs_qual #(.CYC(QUAL_CYC)) u_short_qual (
    .clk(clk),
    .rst_n(rst_n),
    .cond(state == bcs_pkg::ST_SHORT && vbat_above_short), // RL8
    .done(short_ok)
  );
  bcs_qual #(.CYC(QUAL_CYC)) u_pre_qual (
    .clk(clk),
    .rst_n(rst_n),
    .cond(state == bcs_pkg::ST_PRE && vbat_above_low), // RL17
    .done(pre_ok)
  );
  bcs_qual #(.CYC(QUAL_CYC)) u_fast_low_qual (
    .clk(clk),
    .rst_n(rst_n),
    .cond(state == bcs_pkg::ST_FAST && !vbat_above_low), // RL24
    .done(fast_low)
  );
  bcs_qual #(.CYC(TERM_QUAL_CYC)) u_end_qual (
    .clk(clk),
    .rst_n(rst_n),
    .cond(state == bcs_pkg::ST_FAST && fast_charge_current_below_end), // RL19
    .done(end_ok)
  );

  // safety timers
  always_comb begin
    lowbat_clear = 1'b0;
    lowbat_run = 1'b0;
    fast_clear = 1'b0;
    fast_run = 1'b0;
    case (state)
      bcs_pkg::ST_RESET: begin
        lowbat_clear = 1'b1; // RL2
        fast_clear = 1'b1; // RL2
      end
      bcs_pkg::ST_DEAD: begin
        lowbat_run = 1'b1; // RL6
        fast_clear = 1'b1;
      end
      bcs_pkg::ST_SHORT, bcs_pkg::ST_PRE: begin
        lowbat_run = 1'b1; // RL9
        fast_clear = 1'b1;
      end
      bcs_pkg::ST_SHORT_HOLD, bcs_pkg::ST_PRE_HOLD: begin
        fast_clear = 1'b1; // RL14
      end
      bcs_pkg::ST_FAST: begin
        lowbat_clear = 1'b1; // RL22
        fast_run = 1'b1; // RL22
      end
      bcs_pkg::ST_FAST_HOLD: lowbat_clear = 1'b1;
      bcs_pkg::ST_FULL, bcs_pkg::ST_END: begin
        lowbat_clear = 1'b1;
        fast_clear = 1'b1;
      end
      bcs_pkg::ST_FAULT: ;
      default: begin
        lowbat_clear = 1'b1;
        fast_clear = 1'b1;
      end
    endcase
  end

  bcs_safety_timer #(.SEC_CYC(SEC_CYC), .LIM_W(bcs_pkg::TMR_W)) u_lowbat_timer (
    .clk(clk),
    .rst_n(rst_n),
    .clear(lowbat_clear),
    .run(lowbat_run),
    .limit_s(bcs_pkg::TMR_W'(bcs_pkg::LOWBAT_LIMIT_S)), // RL9
    .expired(lowbat_expired)
  );
  // code n gives (n+1) half hours, 30 minutes to 16 hours
  assign fast_limit_s = bcs_pkg::TMR_W'((int'(fast_timer_limit) + 1) * bcs_pkg::FAST_STEP_S);
  bcs_safety_timer #(.SEC_CYC(SEC_CYC), .LIM_W(bcs_pkg::TMR_W)) u_fast_timer (
    .clk(clk),
    .rst_n(rst_n),
    .clear(fast_clear),
    .run(fast_run),
    .limit_s(fast_limit_s), // RL22
    .expired(fast_expired)
  );

  // hold requests only count while the sense input is enabled
  assign temp_hold_req = temp_out_of_range && temp_sense_enable;
  assign temp_clear = !temp_out_of_range || !temp_sense_enable; // RL13
  assign fault_any = lowbat_expired || fast_expired || vbat_ov || vin_ov || vin_uv ||
                     (aux_regulator_fault && !regulator_fault_mask); // RL10

  // priority: fault, then temperature, then progress
  always_comb begin
    next_state = state;
    case (state)
      bcs_pkg::ST_RESET: if (strt_done) next_state = bcs_pkg::ST_DEAD; // RL4
      bcs_pkg::ST_DEAD: if (dead_ok) next_state = bcs_pkg::ST_SHORT; // RL7
      bcs_pkg::ST_SHORT: begin
        if (fault_any) next_state = bcs_pkg::ST_FAULT; // RL10
        else if (temp_hold_req) next_state = bcs_pkg::ST_SHORT_HOLD; // RL11
        else if (short_ok) next_state = bcs_pkg::ST_PRE; // RL8
      end
      bcs_pkg::ST_SHORT_HOLD: if (temp_clear) next_state = bcs_pkg::ST_SHORT; // RL11
      bcs_pkg::ST_PRE: begin
        if (fault_any) next_state = bcs_pkg::ST_FAULT; // RL10
        else if (temp_hold_req) next_state = bcs_pkg::ST_PRE_HOLD; // RL12
        else if (pre_ok) next_state = bcs_pkg::ST_FAST; // RL17
      end
      bcs_pkg::ST_PRE_HOLD: if (temp_clear) next_state = bcs_pkg::ST_PRE; // RL12
      bcs_pkg::ST_FAST: begin
        if (fault_any) next_state = bcs_pkg::ST_FAULT; // RL10
        else if (temp_hold_req) next_state = bcs_pkg::ST_FAST_HOLD;
        else if (fast_low) next_state = bcs_pkg::ST_PRE; // RL24
        else if (end_ok) begin
          next_state = end_enable ? bcs_pkg::ST_END : bcs_pkg::ST_FULL; // RL23
        end
      end
      bcs_pkg::ST_FAST_HOLD: if (temp_clear) next_state = bcs_pkg::ST_FAST;
      bcs_pkg::ST_FULL, bcs_pkg::ST_END, bcs_pkg::ST_FAULT: ;
      default: next_state = bcs_pkg::ST_RESET;
    endcase
  end

  // leaving charge mode restarts the whole cycle and clears a fault
  always_ff @(posedge clk) begin
    if (!rst_n || !charge_enable) begin
      state <= bcs_pkg::ST_RESET; // RL1
    end else begin
      state <= next_state;
    end
  end
  assign charge_state = state;
  // regulation controls follow the state being entered
  always_ff @(posedge clk) begin
    if (!rst_n || !charge_enable) begin
      charge_mode <= bcs_pkg::MODE_OFF;
      switching_en <= 1'b0;
      cv_mode <= 1'b0;
    end else begin
      case (next_state)
        bcs_pkg::ST_DEAD: charge_mode <= bcs_pkg::MODE_DEAD; // RL5
        bcs_pkg::ST_SHORT: charge_mode <= bcs_pkg::MODE_SHORT; // RL7
        bcs_pkg::ST_PRE: charge_mode <= bcs_pkg::MODE_PRE; // RL16
        bcs_pkg::ST_FAST, bcs_pkg::ST_FULL: charge_mode <= bcs_pkg::MODE_FAST;
        default: charge_mode <= bcs_pkg::MODE_OFF;
      endcase
      // holds, end and fault stop all switching
      switching_en <= next_state inside {bcs_pkg::ST_SHORT, bcs_pkg::ST_PRE,
        bcs_pkg::ST_FAST, bcs_pkg::ST_FULL}; // RL11
      cv_mode <= next_state inside {bcs_pkg::ST_FAST, bcs_pkg::ST_FULL} && vbat_at_reg; // RL18
    end
  end

  // blink at 1Hz in the hold states
  assign in_hold = state inside {bcs_pkg::ST_SHORT_HOLD, bcs_pkg::ST_PRE_HOLD,
    bcs_pkg::ST_FAST_HOLD};

  always_ff @(posedge clk) begin
    if (!rst_n || !in_hold) begin
      blink_cnt <= 32'h0;
      blink_level <= 1'b0;
    end else if (blink_cnt == 32'(BLINK_HALF_CYC - 1)) begin
      blink_cnt <= 32'h0;
      blink_level <= !blink_level; // RL15
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  assign drive_low = state inside {bcs_pkg::ST_RESET, bcs_pkg::ST_DEAD, bcs_pkg::ST_SHORT,
    bcs_pkg::ST_PRE, bcs_pkg::ST_FAST};

  // pin only ever pulls low; release lets the pull-up show done or fault
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      charge_status_n_o <= 1'b0;
      charge_status_n_oe_n <= 1'b1;
    end else begin
      charge_status_n_o <= 1'b0;
      if (in_hold) begin
        charge_status_n_oe_n <= blink_level; // RL15
      end else begin
        charge_status_n_oe_n <= !drive_low; // RL3
      end
    end
  end
endmodule // bcs_sequencer
`default_nettype wire

// ### sim/bcs_seq_props.sv
// assertion checker on the charge sequencer ports
`default_nettype none
module bcs_seq_props #(
  parameter int DQ = 4,
  parameter int Q = 8,
  parameter int TQ = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic charge_enable,
  input wire logic vbat_above_3v,
  input wire logic vbat_above_short,
  input wire logic temp_sense_enable,
  input wire logic end_enable,
  input wire logic fast_charge_current_below_end,
  input wire logic vbat_ov,
  input wire logic vin_ov,
  input wire logic vin_uv,
  input wire logic aux_regulator_fault,
  input wire logic regulator_fault_mask,
  input wire logic charge_status_n_o,
  input wire logic charge_status_n_oe_n,
  input wire logic switching_en,
  input wire logic [2:0] charge_mode,
  input wire logic [10:0] charge_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a masked regulator fault must not count
  wire flt = vbat_ov || vin_ov || vin_uv || (aux_regulator_fault && !regulator_fault_mask);
  wire run = charge_state inside {bcs_pkg::ST_SHORT, bcs_pkg::ST_PRE, bcs_pkg::ST_FAST};
  AST_RESET_TO_DEAD: assert property (
    charge_state == bcs_pkg::ST_RESET ##1 charge_state != bcs_pkg::ST_RESET
    |-> charge_state == bcs_pkg::ST_DEAD) else $error("reset left for wrong state");
  AST_STATUS_LOW: assert property (
    charge_state inside {bcs_pkg::ST_RESET, bcs_pkg::ST_DEAD, bcs_pkg::ST_SHORT, bcs_pkg::ST_PRE}
    |=> !charge_status_n_oe_n && !charge_status_n_o) else $error("status pin not low");
  AST_DEAD_CURRENT: assert property (
    charge_state == bcs_pkg::ST_DEAD |-> charge_mode == bcs_pkg::MODE_DEAD)
    else $error("dead battery source not selected");
  AST_DEAD_QUAL: assert property (
    charge_state == bcs_pkg::ST_DEAD ##1 charge_state == bcs_pkg::ST_SHORT
    |-> $past(vbat_above_3v) && $past(vbat_above_3v, DQ)) else $error("dead exit too early");
  AST_SHORT_QUAL: assert property (
    charge_state == bcs_pkg::ST_SHORT ##1 charge_state == bcs_pkg::ST_PRE
    |-> $past(vbat_above_short) && $past(vbat_above_short, Q)) else $error("short exit early");
  AST_SHORT_HOLD_ENTRY: assert property (
    $rose(charge_state == bcs_pkg::ST_SHORT_HOLD) |-> $past(charge_state) == bcs_pkg::ST_SHORT)
    else $error("short hold entered from wrong state");
  AST_PRE_HOLD_ENTRY: assert property (
    $rose(charge_state == bcs_pkg::ST_PRE_HOLD) |-> $past(charge_state) == bcs_pkg::ST_PRE)
    else $error("precondition hold entered from wrong state");
  AST_HOLD_QUIET: assert property (
    charge_state inside {bcs_pkg::ST_SHORT_HOLD, bcs_pkg::ST_PRE_HOLD} |-> !switching_en)
    else $error("switching during temperature hold");
  AST_SENSE_RELEASE: assert property (
    charge_state == bcs_pkg::ST_SHORT_HOLD && !temp_sense_enable && charge_enable
    |=> charge_state == bcs_pkg::ST_SHORT) else $error("hold not released");
  AST_FAULT_ENTRY: assert property (
    run && flt && charge_enable |=> charge_state == bcs_pkg::ST_FAULT)
    else $error("fault not taken");
  AST_END_PICK: assert property (
    charge_state == bcs_pkg::ST_FAST ##1 charge_state inside {bcs_pkg::ST_FULL, bcs_pkg::ST_END}
    |-> (charge_state == bcs_pkg::ST_END) == $past(end_enable) && $past(fast_charge_current_below_end, TQ))
    else $error("wrong end of charge");
  cover property (charge_state == bcs_pkg::ST_SHORT_HOLD);
  cover property (charge_state == bcs_pkg::ST_FAULT);
  cover property (charge_state == bcs_pkg::ST_END);
endmodule // bcs_seq_props
bind bcs_sequencer bcs_seq_props #(.DQ(DEAD_QUAL_CYC), .Q(QUAL_CYC), .TQ(TERM_QUAL_CYC)) u_props (
  .*);
`default_nettype wire

// ### sim/bcs_pack_model.sv
// battery pack, temperature sensor and status pull-up seen by the sequencer
`default_nettype none
module bcs_pack_model (
  input wire logic [1:0] lvl,
  input wire logic hot,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic above_3v,
  output logic above_short,
  output logic above_low,
  output logic temp_bad,
  output logic pin
);
  // thresholds are nested, a higher level trips every lower one
  assign above_3v = lvl >= 2'h1;
  assign above_short = lvl >= 2'h2;
  assign above_low = lvl == 2'h3;
  assign temp_bad = hot;
  // pull-up wins whenever the device lets go
  assign pin = pin_oe_n ? 1'h1 : pin_o;
endmodule // bcs_pack_model
`default_nettype wire

// ### sim/bcs_sequencer_tb_top.sv
// self-checking bench for the battery charge sequencer
`default_nettype none
module bcs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0, charge_enable = 1'h1, vin_ok = 1'h0, fast_charge_current_below_end = 1'h0;
  logic temp_sense_enable = 1'h1, end_enable = 1'h0, vbat_ov = 1'h0, vin_ov = 1'h0;
  logic vin_uv = 1'h0, vbat_at_reg = 1'h0, aux_regulator_fault = 1'h0, hot = 1'h0;
  logic regulator_fault_mask = 1'h0, reg_wr_en = 1'h0, reg_rd_en = 1'h0;
  logic [1:0] lvl = 2'h0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
  logic vbat_above_3v, vbat_above_short, vbat_above_low, temp_out_of_range, pin;
  logic charge_status_n_o, charge_status_n_oe_n, switching_en, cv_mode;
  logic [2:0] charge_mode;
  logic [10:0] charge_state, regulation_voltage_code;
  logic [6:0] fast_current_percent;
  int error_cnt = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  bcs_sequencer #(.DEAD_QUAL_CYC(4), .QUAL_CYC(8), .TERM_QUAL_CYC(16), .BLINK_HALF_CYC(4),
    .SEC_CYC(2), .STRT_UNIT_CYC(4)) DUT (
    .charge_status_n_i(pin), .short_battery_level(), .short_battery_current(),
    .precharge_current(), .end_of_charge_current(), .*);
  bcs_pack_model u_pack (.lvl, .hot, .pin_o(charge_status_n_o), .pin_oe_n(charge_status_n_oe_n),
    .above_3v(vbat_above_3v), .above_short(vbat_above_short), .above_low(vbat_above_low),
    .temp_bad(temp_out_of_range), .pin);
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one register access; a read checks against d
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= w;
    reg_rd_en <= !w;
    @(posedge clk);
    reg_wr_en <= 1'h0;
    reg_rd_en <= 1'h0;
    #1;
    if (!w) chk(11'(reg_rd_data), 11'(d));
  endtask
  // bounded wait; also flags a state reached before lo cycles
  task automatic wait_st(input logic [10:0] s, input int lo, input int hi);
    int i;
    #1;
    for (i = 0; i < hi && charge_state !== s; i++) cyc(1);
    chk(charge_state, s);
    chk(11'(i >= lo), 11'h1);
  endtask
  task automatic t_regs();
    acc(1'h0, bcs_pkg::ADDR_IFAST, bcs_pkg::RST_IFAST);
    acc(1'h0, bcs_pkg::ADDR_STRT_CFG, bcs_pkg::RST_STRT_CFG);
    acc(1'h1, bcs_pkg::ADDR_IFAST, 8'h32);
    chk(11'(fast_current_percent), 11'h032);
    acc(1'h0, bcs_pkg::ADDR_IFAST, 8'h32);
    acc(1'h1, bcs_pkg::ADDR_AUX_REGULATOR_LO, 8'ha5);
    acc(1'h1, bcs_pkg::ADDR_AUX_REGULATOR_HI, 8'h03);
    chk(regulation_voltage_code, 11'h3a5);
    acc(1'h0, 8'h05, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_charge();
    logic b;
    @(posedge clk);
    vin_ok <= 1'h1;
    wait_st(bcs_pkg::ST_DEAD, 6, 12);
    chk(11'(charge_mode), 11'(bcs_pkg::MODE_DEAD));
    chk(11'(pin), 11'h0);
    @(posedge clk);
    lvl <= 2'h1;
    cyc(2);
    @(posedge clk);
    lvl <= 2'h0;
    cyc(3);
    chk(charge_state, bcs_pkg::ST_DEAD);
    @(posedge clk);
    lvl <= 2'h1;
    wait_st(bcs_pkg::ST_SHORT, 3, 6);
    @(posedge clk);
    hot <= 1'h1;
    wait_st(bcs_pkg::ST_SHORT_HOLD, 0, 3);
    chk(11'(switching_en), 11'h0);
    cyc(2);
    b = pin;
    cyc(4);
    chk(11'(pin), 11'(!b));
    @(posedge clk);
    temp_sense_enable <= 1'h0;
    wait_st(bcs_pkg::ST_SHORT, 0, 3);
    @(posedge clk);
    hot <= 1'h0;
    temp_sense_enable <= 1'h1;
    lvl <= 2'h2;
    wait_st(bcs_pkg::ST_PRE, 6, 10);
    @(posedge clk);
    hot <= 1'h1;
    wait_st(bcs_pkg::ST_PRE_HOLD, 0, 3);
    @(posedge clk);
    hot <= 1'h0;
    wait_st(bcs_pkg::ST_PRE, 0, 3);
    @(posedge clk);
    lvl <= 2'h3;
    wait_st(bcs_pkg::ST_FAST, 6, 10);
    @(posedge clk);
    regulator_fault_mask <= 1'h1;
    aux_regulator_fault <= 1'h1;
    vbat_at_reg <= 1'h1;
    cyc(3);
    chk(charge_state, bcs_pkg::ST_FAST);
    chk(11'(cv_mode), 11'h1);
    @(posedge clk);
    end_enable <= 1'h1;
    fast_charge_current_below_end <= 1'h1;
    vbat_at_reg <= 1'h0;
    cyc(2);
    chk(11'(cv_mode), 11'h0);
    wait_st(bcs_pkg::ST_END, 12, 18);
    @(posedge clk);
    vbat_ov <= 1'h1;
    cyc(2);
    chk(charge_state, bcs_pkg::ST_END);
    chk(11'(pin), 11'h1);
    $display("t_charge done");
  endtask
  task automatic t_fault();
    @(posedge clk);
    charge_enable <= 1'h0;
    fast_charge_current_below_end <= 1'h0;
    vbat_ov <= 1'h0;
    wait_st(bcs_pkg::ST_RESET, 0, 3);
    @(posedge clk);
    charge_enable <= 1'h1;
    wait_st(bcs_pkg::ST_FAST, 20, 60);
    @(posedge clk);
    lvl <= 2'h2;
    wait_st(bcs_pkg::ST_PRE, 6, 10);
    @(posedge clk);
    lvl <= 2'h3;
    wait_st(bcs_pkg::ST_FAST, 6, 10);
    @(posedge clk);
    regulator_fault_mask <= 1'h0;
    wait_st(bcs_pkg::ST_FAULT, 0, 3);
    $display("t_fault done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // whole run is under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_charge();
    t_fault();
    tally_and_finish();
  end
endmodule // bcs_sequencer_tb_top
`default_nettype wire
